/* File: rtl/cmc_pkg.sv */
/*
 Package for the CAN operating-mode controller: mode codes, register
 offsets, field positions, reset values and timing constants.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cmc_pkg;

	// Mode codes carried by the request and status fields
	localparam logic [2:0] MODE_NORMAL  = 3'h0;
	localparam logic [2:0] MODE_DISABLE = 3'h1;
	localparam logic [2:0] MODE_LOOP    = 3'h2;
	localparam logic [2:0] MODE_LISTEN  = 3'h3;
	localparam logic [2:0] MODE_INIT    = 3'h4;
	localparam logic [2:0] MODE_ALLMSG  = 3'h7;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CFG2   = 8'h04;
	localparam logic [7:0] OFS_TIMING = 8'h08;
	localparam logic [7:0] OFS_FILTER = 8'h0c;
	localparam logic [7:0] OFS_MASK   = 8'h10;
	localparam logic [7:0] OFS_TXCTL  = 8'h14;
	localparam logic [7:0] OFS_STAT   = 8'h18;

	// Field positions
	localparam int REQ_LSB    = 8;
	localparam int OPM_LSB    = 5;
	localparam int WAKE_FILTER_ENABLE_BIT = 14;
	localparam int TRANSMIT_REQUEST_BIT_BIT  = 0;
	localparam int TRANSMIT_ABORTED_FLAG_BIT  = 1;

	// Reset values
	localparam logic [2:0]  MODE_RST = MODE_INIT;
	localparam logic [31:0] CFG_RST  = 32'h0000_0000;

	// Bus idle needs this many consecutive recessive bits
	localparam int IDLE_BITS = 11;
	localparam int BIT_CNT_W = 4;

	// Wake filter length in clocks
	localparam int WAKE_FILT_CYC = 4;

	// Control-side view of a requested and granted mode
	typedef struct packed {
		logic [2:0] req;
		logic [2:0] opm;
	} cmc_mode_s;

	// Pin-side controls
	typedef struct packed {
		logic can_own_tx;
		logic can_own_rx;
		logic loopback;
		logic tx_allowed;
		logic err_active;
	} cmc_pins_s;

endpackage

/* File: rtl/cmc_idle_det.sv */
/*
 Bus idle detector: counts consecutive recessive bits at bit-sample
 strobes. Assumes rx_i is already synchronised and the bit strobe
 comes from the bit-timing logic on the same clock.
*/
`timescale 1ns/1ps
module cmc_idle_det #(
	parameter int IDLE_BITS = cmc_pkg::IDLE_BITS
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic rx_i,
	input  wire logic bit_stb_i,
	output logic      idle_o
);
	logic [cmc_pkg::BIT_CNT_W-1:0] cnt_r;
	logic [cmc_pkg::BIT_CNT_W-1:0] cnt_nxt;
	localparam logic [cmc_pkg::BIT_CNT_W-1:0] TOP =
		cmc_pkg::BIT_CNT_W'(IDLE_BITS);

	always_comb begin
		cnt_nxt = cnt_r;
		if (bit_stb_i) begin
			if (!rx_i)
				cnt_nxt = '0; // RULE_17
			else if (cnt_r != TOP)
				cnt_nxt = cnt_r + 1'b1; // RULE_17
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	// Saturates, so idle holds through a long quiet bus
	assign idle_o = (cnt_r == TOP); // RULE_03

endmodule // cmc_idle_det

/* File: rtl/cmc_wake_filt.sv */
/*
 Wake-up low-pass filter on the receive line: a dominant level must
 persist for a few clocks before it counts as bus activity.
 Assumes rx_i is synchronised to clk_i.
*/
`timescale 1ns/1ps
module cmc_wake_filt #(
	parameter int FILT_CYC = cmc_pkg::WAKE_FILT_CYC
) (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic rx_i,
	input  wire logic en_i,
	output logic      wake_o
);
	logic [FILT_CYC-1:0] hist_r;
	logic [FILT_CYC-1:0] hist_nxt;

	always_comb begin
		hist_nxt = {hist_r[FILT_CYC-2:0], ~rx_i};
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			hist_r <= '0;
		else
			hist_r <= hist_nxt;
	end

	// Filter off: any dominant sample wakes
	assign wake_o = en_i ? (&hist_r) : hist_r[0]; // RULE_11

endmodule // cmc_wake_filt

/* File: rtl/cmc_mode_ctrl.sv */
/*
 CAN operating-mode controller with an APB register slave.
 Assumes a bit-sample strobe and frame status from the protocol
 engine on clk_i; the receive pin is asynchronous.
*/
// Notes on behaviour
// (RULE_01) Mode request field at control bits 10:8
// (RULE_02) Mode status field at control bits 7:5
// (RULE_03) Defer mode change until bus idle
// (RULE_04) Init mode: no traffic, clear error counters
// (RULE_05) Config registers writable only in init mode
// (RULE_06) No init entry while transmitting
// (RULE_07) Disable: no traffic, wake flag, counters kept
// (RULE_08) Request 001 enters disable after idle
// (RULE_09) Status reads 001 once disabled
// (RULE_10) Disable releases both pins to port
// (RULE_11) Wake filter enable at config2 bit 14
// (RULE_12) Disable aborts waiting transmission, sets abort
// (RULE_13) Request 000 selects normal bus operation
// (RULE_14) Listen-only: passive, no errors, no acks
// (RULE_15) Request 111 ignores errors, keeps partial frames
// (RULE_16) Loopback ties tx to rx internally
// (RULE_17) Idle counter restarts on dominant bit
// (RULE_18) Status keeps old mode until change
`timescale 1ns/1ps
module cmc_mode_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              can_receive_pin_i,
	input  wire logic              bit_stb_i,
	input  wire logic              tx_busy_i,
	input  wire logic              err_event_i,
	input  wire logic              sleep_i,
	input  wire logic              core_tx_i,
	output logic                   can_transmit_pin_o,
	output logic                   can_transmit_pin_oe_o,
	output logic                   can_receive_input_o,
	output cmc_pkg::cmc_pins_s     pins_o,
	output logic                   err_cnt_clr_o,
	output logic                   tx_start_o,
	output logic                   copy_partial_o
);
	logic                  rx_meta_r;
	logic                  rx_sync_r;
	cmc_pkg::cmc_mode_s    mode_r;
	cmc_pkg::cmc_mode_s    mode_nxt;
	logic [31:0]           cfg2_r;
	logic [31:0]           cfg2_nxt;
	logic [31:0]           timing_r;
	logic [31:0]           timing_nxt;
	logic [31:0]           filter_r;
	logic [31:0]           filter_nxt;
	logic [31:0]           mask_r;
	logic [31:0]           mask_nxt;
	logic                  transmit_request_bit_r;
	logic                  transmit_request_bit_nxt;
	logic                  transmit_aborted_flag_r;
	logic                  transmit_aborted_flag_nxt;
	logic                  wake_interrupt_flag_r;
	logic                  wake_interrupt_flag_nxt;
	logic                  txwait_r;
	logic                  txwait_nxt;
	logic [31:0]           prdata_nxt;
	logic                  prdata_valid_r;
	logic                  prdata_valid_nxt;
	logic                  idle;
	logic                  wake;
	logic                  access;
	logic                  wr;
	logic                  cfg_open;
	logic                  change_ok;
	logic                  mapped;
	logic                  tx_mode;
	logic                  int_rx;

	typedef enum {
		CMC_ST_RUN,
		CMC_ST_WAIT
	} cmc_st_e;
	cmc_st_e st_r;
	cmc_st_e st_nxt;

	// Two-stage sync; only the second stage feeds logic
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end else begin
			rx_meta_r <= can_receive_pin_i;
			rx_sync_r <= rx_meta_r;
		end
	end

	// Loopback feeds the internal receiver from the transmitter
	assign int_rx = (mode_r.opm == cmc_pkg::MODE_LOOP) ? core_tx_i
		: rx_sync_r; // RULE_16

	cmc_idle_det #(
		.IDLE_BITS(cmc_pkg::IDLE_BITS)
	) u_idle (
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.rx_i     (int_rx),
		.bit_stb_i(bit_stb_i),
		.idle_o   (idle)
	);

	cmc_wake_filt #(
		.FILT_CYC(cmc_pkg::WAKE_FILT_CYC)
	) u_wake (
		.clk_i  (clk_i),
		.reset_i(reset_i),
		.rx_i   (rx_sync_r),
		.en_i   (cfg2_r[cmc_pkg::WAKE_FILTER_ENABLE_BIT] & sleep_i), // RULE_11
		.wake_o (wake)
	);

	assign access   = psel_i & penable_i;
	assign wr       = access & pwrite_i;
	assign cfg_open = (mode_r.opm == cmc_pkg::MODE_INIT); // RULE_05
	assign tx_mode  = (mode_r.opm == cmc_pkg::MODE_NORMAL) ||
		(mode_r.opm == cmc_pkg::MODE_LOOP) ||
		(mode_r.opm == cmc_pkg::MODE_ALLMSG);

	// Init may only be entered between frames; leaving init or disable is at once, others need idle
	always_comb begin
		if (mode_r.req == cmc_pkg::MODE_INIT)
			change_ok = !tx_busy_i; // RULE_06
		else if (mode_r.opm == cmc_pkg::MODE_INIT ||
			mode_r.opm == cmc_pkg::MODE_DISABLE)
			change_ok = 1'b1;
		else
			change_ok = idle && !tx_busy_i; // RULE_03 RULE_08
	end

	always_comb begin
		mapped = 1'b1;
		case (paddr_i)
			cmc_pkg::OFS_CTRL,
			cmc_pkg::OFS_CFG2,
			cmc_pkg::OFS_TIMING,
			cmc_pkg::OFS_FILTER,
			cmc_pkg::OFS_MASK,
			cmc_pkg::OFS_TXCTL,
			cmc_pkg::OFS_STAT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Register and mode next-state
	always_comb begin
		mode_nxt   = mode_r;
		cfg2_nxt   = cfg2_r;
		timing_nxt = timing_r;
		filter_nxt = filter_r;
		mask_nxt   = mask_r;
		transmit_request_bit_nxt  = transmit_request_bit_r;
		transmit_aborted_flag_nxt  = transmit_aborted_flag_r;
		wake_interrupt_flag_nxt  = wake_interrupt_flag_r;
		st_nxt     = st_r;
		// The mode request stays writable so init can be left
		if (wr && paddr_i == cmc_pkg::OFS_CTRL)
			mode_nxt.req = pwdata_i[cmc_pkg::REQ_LSB +: 3]; // RULE_01
		if (wr && cfg_open) begin
			case (paddr_i)
				cmc_pkg::OFS_CFG2:   cfg2_nxt   = pwdata_i; // RULE_05
				cmc_pkg::OFS_TIMING: timing_nxt = pwdata_i; // RULE_05
				cmc_pkg::OFS_FILTER: filter_nxt = pwdata_i; // RULE_05
				cmc_pkg::OFS_MASK:   mask_nxt   = pwdata_i; // RULE_05
				default: ;
			endcase
		end
		// Write one clears the sticky flags; hardware set wins
		if (wr && paddr_i == cmc_pkg::OFS_STAT) begin
			if (pwdata_i[cmc_pkg::TRANSMIT_ABORTED_FLAG_BIT])
				transmit_aborted_flag_nxt = 1'b0;
			if (pwdata_i[2])
				wake_interrupt_flag_nxt = 1'b0;
		end
		if (wr && paddr_i == cmc_pkg::OFS_TXCTL &&
			pwdata_i[cmc_pkg::TRANSMIT_REQUEST_BIT_BIT])
			transmit_request_bit_nxt = 1'b1;
		if (mode_r.opm == cmc_pkg::MODE_DISABLE && wake)
			wake_interrupt_flag_nxt = 1'b1; // RULE_07
		case (st_r)
			CMC_ST_RUN: begin
				if (mode_r.req != mode_r.opm)
					st_nxt = CMC_ST_WAIT;
			end
			CMC_ST_WAIT: begin
				if (mode_r.req == mode_r.opm)
					st_nxt = CMC_ST_RUN;
				else if (change_ok) begin
					mode_nxt.opm = mode_r.req; // RULE_18 RULE_09
					st_nxt = CMC_ST_RUN;
				end
			end
			default: st_nxt = CMC_ST_RUN;
		endcase
		// Pending transmission aborted by a disable request
		if (transmit_request_bit_r && !tx_busy_i &&
			mode_r.req == cmc_pkg::MODE_DISABLE) begin
			transmit_request_bit_nxt = 1'b0; // RULE_12
			transmit_aborted_flag_nxt = 1'b1; // RULE_12
		end else if (transmit_request_bit_r && tx_mode && idle && !tx_busy_i &&
			txwait_r) begin
			transmit_request_bit_nxt = 1'b0;
		end
	end

	// Transmission waits for idle on two consecutive clocks with the request pending, then starts
	always_comb begin
		txwait_nxt = transmit_request_bit_r && tx_mode && idle; // RULE_12
	end
	assign tx_start_o = txwait_r && transmit_request_bit_r && tx_mode && idle &&
		!tx_busy_i && mode_r.req != cmc_pkg::MODE_DISABLE;

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		// Data only for the answer cycle, zero right after it
		if (access && !pwrite_i && !prdata_valid_r) begin
			case (paddr_i)
				cmc_pkg::OFS_CTRL: begin
					prdata_nxt[cmc_pkg::REQ_LSB +: 3] = mode_r.req;
					prdata_nxt[cmc_pkg::OPM_LSB +: 3] = mode_r.opm; // RULE_02
				end
				cmc_pkg::OFS_CFG2:   prdata_nxt = cfg2_r;
				cmc_pkg::OFS_TIMING: prdata_nxt = timing_r;
				cmc_pkg::OFS_FILTER: prdata_nxt = filter_r;
				cmc_pkg::OFS_MASK:   prdata_nxt = mask_r;
				cmc_pkg::OFS_TXCTL:
					prdata_nxt[cmc_pkg::TRANSMIT_REQUEST_BIT_BIT] = transmit_request_bit_r;
				cmc_pkg::OFS_STAT: begin
					prdata_nxt[cmc_pkg::TRANSMIT_ABORTED_FLAG_BIT] = transmit_aborted_flag_r;
					prdata_nxt[2] = wake_interrupt_flag_r;
					prdata_nxt[3] = idle;
				end
				default: prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode_r   <= '{req: cmc_pkg::MODE_RST, opm: cmc_pkg::MODE_RST};
			cfg2_r   <= cmc_pkg::CFG_RST;
			timing_r <= cmc_pkg::CFG_RST;
			filter_r <= cmc_pkg::CFG_RST;
			mask_r   <= cmc_pkg::CFG_RST;
			transmit_request_bit_r  <= 1'b0;
			transmit_aborted_flag_r  <= 1'b0;
			wake_interrupt_flag_r  <= 1'b0;
			txwait_r <= 1'b0;
			st_r     <= CMC_ST_RUN;
			prdata_o <= 32'h0000_0000;
		end else begin
			mode_r   <= mode_nxt;
			cfg2_r   <= cfg2_nxt;
			timing_r <= timing_nxt;
			filter_r <= filter_nxt;
			mask_r   <= mask_nxt;
			transmit_request_bit_r  <= transmit_request_bit_nxt;
			transmit_aborted_flag_r  <= transmit_aborted_flag_nxt;
			wake_interrupt_flag_r  <= wake_interrupt_flag_nxt;
			txwait_r <= txwait_nxt;
			st_r     <= st_nxt;
			prdata_o <= prdata_nxt;
		end
	end

	// Zero-wait write, one-wait read so data comes from a flop
	assign pready_o  = !pwrite_i ? (access && prdata_valid_r) : 1'b1;
	always_comb begin
		prdata_valid_nxt = access && !pwrite_i && !prdata_valid_r;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i)
			prdata_valid_r <= 1'b0;
		else
			prdata_valid_r <= prdata_valid_nxt;
	end
	assign pslverr_o = access && !mapped;

	// Pin ownership per mode
	always_comb begin
		pins_o = '0;
		case (mode_r.opm)
			cmc_pkg::MODE_NORMAL: begin
				pins_o.can_own_tx = 1'b1; // RULE_13
				pins_o.can_own_rx = 1'b1; // RULE_13
				pins_o.tx_allowed = 1'b1;
				pins_o.err_active = 1'b1;
			end
			cmc_pkg::MODE_LISTEN: begin
				pins_o.can_own_rx = 1'b1; // RULE_14
			end
			cmc_pkg::MODE_ALLMSG: begin
				pins_o.can_own_tx = 1'b1; // RULE_15
				pins_o.can_own_rx = 1'b1;
				pins_o.tx_allowed = 1'b1;
			end
			cmc_pkg::MODE_LOOP: begin
				pins_o.loopback   = 1'b1; // RULE_16
				pins_o.tx_allowed = 1'b1;
				pins_o.err_active = 1'b1;
			end
			default: pins_o = '0; // RULE_04 RULE_07 RULE_10
		endcase
	end

	assign can_transmit_pin_o    = core_tx_i | !pins_o.tx_allowed;
	assign can_transmit_pin_oe_o = pins_o.can_own_tx; // RULE_10 RULE_14
	assign can_receive_input_o   = int_rx;
	assign err_cnt_clr_o = (mode_r.opm == cmc_pkg::MODE_INIT); // RULE_04
	assign copy_partial_o = err_event_i &&
		(mode_r.opm == cmc_pkg::MODE_ALLMSG); // RULE_15

endmodule // cmc_mode_ctrl

/* File: testbench/cmc_mode_ctrl_assertions.sv */
/*
 Checker for the CAN mode controller, bound to its top ports.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cmc_mode_ctrl_chk (
	input wire logic               clk_i,
	input wire logic               reset_i,
	input wire logic               psel_i,
	input wire logic               penable_i,
	input wire logic               pwrite_i,
	input wire logic [31:0]        prdata_o,
	input wire logic               pready_o,
	input wire logic               pslverr_o,
	input wire logic               err_event_i,
	input wire logic               core_tx_i,
	input wire logic               can_transmit_pin_o,
	input wire logic               can_transmit_pin_oe_o,
	input wire logic               can_receive_input_o,
	input wire cmc_pkg::cmc_pins_s pins_o,
	input wire logic               err_cnt_clr_o,
	input wire logic               tx_start_o,
	input wire logic               copy_partial_o
);
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_write_no_wait: assert property (
		psel_i && penable_i && pwrite_i |-> pready_o)
		else $error("write not answered at once");
	a_read_one_wait: assert property (
		psel_i && $rose(penable_i) && !pwrite_i
		|-> !pready_o ##1 pready_o)
		else $error("read answer timing wrong");
	a_rdata_idle: assert property (
		!pready_o |-> prdata_o == 32'h0)
		else $error("read data not zero outside answer");
	a_err_in_access: assert property (
		pslverr_o |-> psel_i && penable_i)
		else $error("slave error outside access");
	a_init_quiet: assert property (
		err_cnt_clr_o |-> !can_transmit_pin_oe_o && !tx_start_o &&
		can_transmit_pin_o)
		else $error("traffic in init mode");
	a_tx_recessive: assert property (
		!pins_o.tx_allowed |-> can_transmit_pin_o)
		else $error("tx pin dominant while not allowed");
	a_oe_owner: assert property (
		can_transmit_pin_oe_o == pins_o.can_own_tx &&
		(!can_transmit_pin_oe_o ||
		(pins_o.can_own_rx && !pins_o.loopback)))
		else $error("tx enable disagrees with ownership");
	a_loop_route: assert property (
		pins_o.loopback |-> can_receive_input_o == core_tx_i &&
		!pins_o.can_own_tx && !pins_o.can_own_rx)
		else $error("loopback routing wrong");
	a_copy_cause: assert property (
		copy_partial_o |-> err_event_i || $past(err_event_i))
		else $error("partial copy without error");
	a_start_allowed: assert property (
		tx_start_o |-> pins_o.tx_allowed)
		else $error("tx start in passive mode");
endmodule // cmc_mode_ctrl_chk

bind cmc_mode_ctrl cmc_mode_ctrl_chk cmc_mode_ctrl_chk_inst (
	.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .err_event_i(err_event_i),
	.core_tx_i(core_tx_i), .can_transmit_pin_o(can_transmit_pin_o),
	.can_transmit_pin_oe_o(can_transmit_pin_oe_o),
	.can_receive_input_o(can_receive_input_o), .pins_o(pins_o),
	.err_cnt_clr_o(err_cnt_clr_o), .tx_start_o(tx_start_o),
	.copy_partial_o(copy_partial_o));

/* File: testbench/cmc_bus_node.sv */
/*
 Model of the other bus nodes: bit strobes and a receive level.
 Assumes the bench sets busy_i to keep the bus from going idle.
*/
`timescale 1ns/1ps
module cmc_bus_node (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic busy_i,
	output logic      rx_o,
	output logic      bit_stb_o
);
	logic [1:0] div_r;
	logic [1:0] bit_r;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			div_r <= 2'h0;
			bit_r <= 2'h0;
			rx_o <= 1'b1;
			bit_stb_o <= 1'b0;
		end else begin
			div_r <= div_r + 2'h1;
			bit_stb_o <= (div_r == 2'h1);
			if (div_r == 2'h3) begin
				bit_r <= bit_r + 2'h1;
				// One dominant bit in four: never 11 recessive
				rx_o <= !(busy_i && bit_r == 2'h3);
			end
		end
	end
endmodule // cmc_bus_node

/* File: testbench/tb.sv */
/*
 Self-checking bench for the CAN mode controller over APB.
 Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module tb;
	logic        clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, rd, v, seed = 32'he96381e1;
	logic        err, rx, stb, nbusy = 0, txb = 0, errev = 0, ctx = 1, c;
	logic        oe, rxi, rdy, slv, txo, tst, slp = 0, txr = 0;
	logic [31:0] prd;
	cmc_pkg::cmc_pins_s pins;
	logic        clr, cp;
	int          fail_count = 0, cmp_count = 0, cyc = 0, i;

	always #4 clk_i = !clk_i;

	cmc_bus_node cmc_bus_node_inst (.clk_i(clk_i), .reset_i(reset_i),
		.busy_i(nbusy), .rx_o(rx), .bit_stb_o(stb));
	cmc_mode_ctrl cmc_mode_ctrl_inst (.clk_i(clk_i), .reset_i(reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prd),
		.pready_o(rdy), .pslverr_o(slv), .can_receive_pin_i(rx),
		.bit_stb_i(stb), .tx_busy_i(txb), .err_event_i(errev),
		.sleep_i(slp), .core_tx_i(ctx), .can_transmit_pin_o(txo),
		.can_transmit_pin_oe_o(oe), .can_receive_input_o(rxi),
		.pins_o(pins), .err_cnt_clr_o(clr), .tx_start_o(tst),
		.copy_partial_o(cp));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [31:0] fld(input logic [31:0] w, input int lsb);
		return {29'h0, w[lsb+:3]};
	endfunction

	task automatic stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic r;
		@(posedge clk_i);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1;
		r = 0;
		// Only pready or the bench timeout ends this wait
		while (!r) begin
			// Settled here: equals what the next rising edge samples
			@(negedge clk_i);
			r = rdy;
			rd = prd;
			err = slv;
			@(posedge clk_i);
		end
		psel <= 0;
		penable <= 0;
	endtask

	task automatic req(input logic [2:0] m);
		apb(1, cmc_pkg::OFS_CTRL, {21'h0, m, 8'h0});
	endtask

	// Bounded poll; the grant may wait for 11 idle bits
	task automatic wait_opm(input logic [2:0] m);
		for (i = 0; i < 60; i++) begin
			apb(0, cmc_pkg::OFS_CTRL, 32'h0);
			if (rd[7:5] === m) break;
		end
		chk(fld(rd, cmc_pkg::OPM_LSB), {29'h0, m});
	endtask

	always @(posedge clk_i) begin
		// Random tx bits only while looped back, else idle recessive
		ctx <= txr ? ^rnd() : 1'b1;
		cyc++;
		if (cyc == 30000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 0;
		apb(0, cmc_pkg::OFS_CTRL, 32'h0);
		chk(fld(rd, cmc_pkg::OPM_LSB), 32'h4);
		chk(fld(rd, cmc_pkg::REQ_LSB), 32'h4);
		chk({31'h0, clr}, 32'h1);
		chk({31'h0, txo}, 32'h1);
		apb(0, 8'h1c, 32'h0);
		chk({31'h0, err}, 32'h1);
		v = rnd();
		apb(1, cmc_pkg::OFS_TIMING, v);
		apb(0, cmc_pkg::OFS_TIMING, 32'h0);
		chk(rd, v);
		apb(1, cmc_pkg::OFS_CFG2, 32'h1 << cmc_pkg::WAKE_FILTER_ENABLE_BIT);
		apb(0, cmc_pkg::OFS_CFG2, 32'h0);
		chk(rd, 32'h1 << cmc_pkg::WAKE_FILTER_ENABLE_BIT);
		req(cmc_pkg::MODE_NORMAL);
		wait_opm(cmc_pkg::MODE_NORMAL);
		chk({31'h0, oe}, 32'h1);
		apb(1, cmc_pkg::OFS_TIMING, ~v);
		apb(0, cmc_pkg::OFS_TIMING, 32'h0);
		chk(rd, v);
		nbusy <= 1;
		// Saturated idle count must first see a dominant bit
		repeat (40) @(posedge clk_i);
		req(cmc_pkg::MODE_LISTEN);
		repeat (100) @(posedge clk_i);
		apb(0, cmc_pkg::OFS_CTRL, 32'h0);
		chk(fld(rd, cmc_pkg::OPM_LSB), 32'h0);
		chk(fld(rd, cmc_pkg::REQ_LSB), 32'h3);
		nbusy <= 0;
		wait_opm(cmc_pkg::MODE_LISTEN);
		chk({31'h0, oe}, 32'h0);
		req(cmc_pkg::MODE_LOOP);
		wait_opm(cmc_pkg::MODE_LOOP);
		txr <= 1;
		repeat (8) begin
			@(negedge clk_i);
			chk({31'h0, rxi}, {31'h0, ctx});
		end
		@(posedge clk_i);
		txr <= 0;
		req(cmc_pkg::MODE_ALLMSG);
		wait_opm(cmc_pkg::MODE_ALLMSG);
		@(posedge clk_i) errev <= 1;
		@(negedge clk_i) c = cp;
		@(posedge clk_i) errev <= 0;
		@(negedge clk_i) c = c | cp;
		chk({31'h0, c}, 32'h1);
		req(cmc_pkg::MODE_NORMAL);
		wait_opm(cmc_pkg::MODE_NORMAL);
		nbusy <= 1;
		repeat (40) @(posedge clk_i);
		apb(1, cmc_pkg::OFS_TXCTL, 32'h1);
		apb(0, cmc_pkg::OFS_TXCTL, 32'h0);
		chk({31'h0, rd[cmc_pkg::TRANSMIT_REQUEST_BIT_BIT]}, 32'h1);
		chk({31'h0, tst}, 32'h0);
		req(cmc_pkg::MODE_DISABLE);
		repeat (4) @(posedge clk_i);
		apb(0, cmc_pkg::OFS_STAT, 32'h0);
		chk({31'h0, rd[cmc_pkg::TRANSMIT_ABORTED_FLAG_BIT]}, 32'h1);
		apb(0, cmc_pkg::OFS_TXCTL, 32'h0);
		chk({31'h0, rd[cmc_pkg::TRANSMIT_REQUEST_BIT_BIT]}, 32'h0);
		apb(0, cmc_pkg::OFS_CTRL, 32'h0);
		chk(fld(rd, cmc_pkg::OPM_LSB), 32'h0);
		nbusy <= 0;
		wait_opm(cmc_pkg::MODE_DISABLE);
		chk({30'h0, oe, pins.can_own_rx}, 32'h0);
		apb(0, cmc_pkg::OFS_STAT, 32'h0);
		chk({31'h0, rd[2]}, 32'h0);
		// Dominant bits last four clocks, enough for the filter
		slp <= 1;
		nbusy <= 1;
		repeat (40) @(posedge clk_i);
		apb(0, cmc_pkg::OFS_STAT, 32'h0);
		chk({31'h0, rd[2]}, 32'h1);
		slp <= 0;
		nbusy <= 0;
		repeat (24) @(posedge clk_i);
		apb(1, cmc_pkg::OFS_STAT, 32'h4);
		apb(0, cmc_pkg::OFS_STAT, 32'h0);
		chk({31'h0, rd[2]}, 32'h0);
		txb <= 1;
		req(cmc_pkg::MODE_INIT);
		repeat (60) @(posedge clk_i);
		apb(0, cmc_pkg::OFS_CTRL, 32'h0);
		chk(fld(rd, cmc_pkg::OPM_LSB), 32'h1);
		txb <= 0;
		wait_opm(cmc_pkg::MODE_INIT);
		chk({31'h0, clr}, 32'h1);
		stop_test();
	end
endmodule // tb
